// file: common/srpc_pkg.sv
package srpc_pkg;
  localparam int unsigned SRPC_CLK_HZ = 25_000_000;
  localparam int unsigned SRPC_TICK_MS = 1;
  localparam int unsigned SRPC_TICK_CYC = SRPC_CLK_HZ / 1000 * SRPC_TICK_MS;

  // Register indices
  localparam logic [3:0] SRPC_ADR_SEL = 4'h0;
  localparam logic [3:0] SRPC_ADR_ACC = 4'h1;
  localparam logic [3:0] SRPC_ADR_DEC = 4'h2;
  localparam logic [3:0] SRPC_ADR_RUN = 4'h3;
  localparam logic [3:0] SRPC_ADR_LIM = 4'h4;
  localparam logic [3:0] SRPC_ADR_TIME = 4'h5;
  localparam logic [3:0] SRPC_ADR_ACC2 = 4'h6;
  localparam logic [3:0] SRPC_ADR_LIM2 = 4'h7;
  localparam logic [3:0] SRPC_ADR_CTRL = 4'h8;
  localparam logic [3:0] SRPC_ADR_STAT = 4'h9;
  localparam logic [3:0] SRPC_ADR_EFF = 4'ha;

  // Field positions
  localparam int SRPC_SEL_ACC_OFF = 0;
  localparam int SRPC_SEL_DEC_OFF = 1;
  localparam int SRPC_SEL_RUN_OFF = 2;
  localparam int SRPC_SEL_DEC2 = 3;
  localparam int SRPC_CTL_VF = 0;
  localparam int SRPC_CTL_MSW = 1;

  // Reset values
  localparam logic [3:0] SRPC_RST_SEL = 4'h0;
  localparam logic [7:0] SRPC_RST_ACC = 8'h96;
  localparam logic [7:0] SRPC_RST_RUN = 8'h96;
  localparam logic [7:0] SRPC_RST_LIM = 8'h32;
  localparam logic [7:0] SRPC_RST_TIME = 8'h0a;
  localparam logic [1:0] SRPC_RST_CTRL = 2'h1;

  // Setting ranges
  localparam logic [10:0] SRPC_ACC_MIN = 11'h014;
  localparam logic [10:0] SRPC_PCT_MAX = 11'h0c8;
  localparam logic [10:0] SRPC_RUN_MIN = 11'h01e;
  localparam logic [10:0] SRPC_LIM_MIN = 11'h001;
  localparam logic [10:0] SRPC_LIM_MAX = 11'h064;
  localparam logic [10:0] SRPC_TIME_MIN = 11'h002;
  localparam logic [10:0] SRPC_TIME_MAX = 11'h064;
  localparam logic [8:0] SRPC_SLOW_BAND = 9'h00f;
  localparam logic [8:0] SRPC_RUN_HYST = 9'h002;

  // Bus window and default per class: 200 V, 400 V, 575 V, 690 V
  localparam logic [10:0] SRPC_DEC_MIN [4] = '{11'h14a, 11'h294, 11'h384, 11'h438};
  localparam logic [10:0] SRPC_DEC_MAX [4] = '{11'h19a, 11'h334, 11'h3e8, 11'h4b0};
  localparam logic [10:0] SRPC_DEC_DEF [4] = '{11'h181, 11'h302, 11'h3b6, 11'h474};

  typedef enum logic [1:0] {
    SRPC_PH_STOP = 2'b00,
    SRPC_PH_ACC = 2'b01,
    SRPC_PH_RUN = 2'b11,
    SRPC_PH_DEC = 2'b10
  } srpc_phase_t;

  typedef enum logic [1:0] {
    SRPC_RUN_IDLE = 2'b00,
    SRPC_RUN_TIMING = 2'b01,
    SRPC_RUN_LOWER = 2'b11,
    SRPC_RUN_BACK = 2'b10
  } srpc_run_st_t;

  function automatic logic [10:0] srpc_clamp(input logic [10:0] v, input logic [10:0] lo,
                                             input logic [10:0] hi);
    if (v < lo) begin
      srpc_clamp = lo;
    end else if (v > hi) begin
      srpc_clamp = hi;
    end else begin
      srpc_clamp = v;
    end
  endfunction
endpackage

// file: rtl/srpc_tick.sv
`timescale 1ns/1ps
`default_nettype none
module srpc_tick #(
  parameter int unsigned PERIOD = 25000
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_run,
  output logic o_tick
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  if (PERIOD < 2) begin : g_chk
    $error("srpc_tick: PERIOD must be at least 2");
  end

  logic [CW-1:0] cnt_r;
  wire wrap = cnt_r == LAST;

  // Restarts from zero whenever the window closes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r <= (!i_run || wrap) ? '0 : cnt_r + CW'(1);
      o_tick <= i_run && wrap;
    end
  end
endmodule
`default_nettype wire

// file: rtl/srpc_cp_div.sv
`timescale 1ns/1ps
`default_nettype none
module srpc_cp_div #(
  parameter int NW = 24,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Operands
  input wire logic i_start,
  input wire logic [NW-1:0] i_num,
  input wire logic [DW-1:0] i_den,
  // Result
  output logic o_busy,
  output logic o_done,
  output logic [NW-1:0] o_quo
);
  localparam int CW = $clog2(NW + 1);

  if (NW < 2 || DW < 1) begin : g_chk
    $error("srpc_cp_div: widths too small");
  end

  logic [DW:0] rem_r;
  logic [DW-1:0] den_r;
  logic [CW-1:0] cnt_r;
  // Quotient bits shift in where numerator bits shift out
  wire [DW:0] shl = {rem_r[DW-1:0], o_quo[NW-1]};
  wire ge = shl >= {1'b0, den_r};
  wire [DW:0] rem_nxt = ge ? shl - {1'b0, den_r} : shl;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      o_quo <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (!o_busy) begin
      o_done <= 1'b0;
      if (i_start) begin
        rem_r <= '0;
        den_r <= i_den;
        o_quo <= i_num;
        cnt_r <= CW'(NW);
        o_busy <= 1'b1;
      end
    end else begin
      rem_r <= rem_nxt;
      o_quo <= {o_quo[NW-2:0], ge};
      cnt_r <= cnt_r - CW'(1);
      o_busy <= cnt_r != CW'(1);
      o_done <= cnt_r == CW'(1);
    end
  end
endmodule
`default_nettype wire

// file: rtl/srpc_stall_ctl.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module srpc_stall_ctl
  import srpc_pkg::*;
#(
  parameter int VOLT_CLASS = 1,
  parameter int unsigned TICK_CYC = SRPC_TICK_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [15:0] o_rd_data,
  // Measurements
  input wire logic [8:0] i_out_cur_pct,
  input wire logic [10:0] i_bus_volt,
  input wire logic [15:0] i_out_freq,
  input wire logic [15:0] i_base_freq,
  // Ramp generator and motor select
  input wire srpc_phase_t i_ramp_phase,
  input wire logic i_at_ref,
  input wire logic i_motor2_sel,
  // Ramp intervention
  output logic [7:0] o_acc_rate,
  output logic o_acc_halt,
  output logic o_dec_hold,
  output logic o_run_lower,
  output logic o_run_dec2,
  output logic o_run_back
);
  if (VOLT_CLASS < 0 || VOLT_CLASS > 3) begin : g_chk
    $error("srpc_stall_ctl: VOLT_CLASS must be 0 to 3");
  end

  // Settings
  logic [3:0] sel_r;
  logic [7:0] acc_lvl_r [2];
  logic [7:0] acc_lim_r [2];
  logic [10:0] dec_lvl_r;
  logic [7:0] run_lvl_r;
  logic [7:0] run_time_r;
  logic [1:0] ctrl_r;
  // Block state
  logic [7:0] cp_thr_r;
  logic [7:0] eff_thr_r;
  logic [6:0] ms_cnt_r;
  srpc_run_st_t run_st_r;
  srpc_run_st_t run_st_nxt;
  logic [15:0] rd_nxt;

  // Write decode, out-of-range values are saturated into range
  wire [10:0] wd = |i_wr_data[15:11] ? 11'h7ff : i_wr_data[10:0];
  wire wr_sel = i_wr_en && i_addr == SRPC_ADR_SEL;
  wire wr_acc = i_wr_en && i_addr == SRPC_ADR_ACC;
  wire wr_dec = i_wr_en && i_addr == SRPC_ADR_DEC;
  wire wr_run = i_wr_en && i_addr == SRPC_ADR_RUN;
  wire wr_lim = i_wr_en && i_addr == SRPC_ADR_LIM;
  wire wr_time = i_wr_en && i_addr == SRPC_ADR_TIME;
  wire wr_acc2 = i_wr_en && i_addr == SRPC_ADR_ACC2;
  wire wr_lim2 = i_wr_en && i_addr == SRPC_ADR_LIM2;
  wire wr_ctrl = i_wr_en && i_addr == SRPC_ADR_CTRL;
  wire [10:0] wd_acc = srpc_clamp(wd, SRPC_ACC_MIN, SRPC_PCT_MAX);
  wire [10:0] wd_dec = srpc_clamp(wd, SRPC_DEC_MIN[VOLT_CLASS], SRPC_DEC_MAX[VOLT_CLASS]);
  wire [10:0] wd_run = srpc_clamp(wd, SRPC_RUN_MIN, SRPC_PCT_MAX);
  wire [10:0] wd_time = srpc_clamp(wd, SRPC_TIME_MIN, SRPC_TIME_MAX);
  wire [10:0] wd_lim = srpc_clamp(wd, SRPC_LIM_MIN, SRPC_LIM_MAX);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_r <= SRPC_RST_SEL;
      acc_lvl_r <= '{SRPC_RST_ACC, SRPC_RST_ACC};
      acc_lim_r <= '{SRPC_RST_LIM, SRPC_RST_LIM};
      dec_lvl_r <= SRPC_DEC_DEF[VOLT_CLASS];
      run_lvl_r <= SRPC_RST_RUN;
      run_time_r <= SRPC_RST_TIME;
      ctrl_r <= SRPC_RST_CTRL;
    end else begin
      if (wr_sel) sel_r <= i_wr_data[3:0];
      if (wr_acc) acc_lvl_r[0] <= wd_acc[7:0];
      if (wr_acc2) acc_lvl_r[1] <= wd_acc[7:0];
      if (wr_lim) acc_lim_r[0] <= wd_lim[7:0];
      if (wr_lim2) acc_lim_r[1] <= wd_lim[7:0];
      if (wr_dec) dec_lvl_r <= wd_dec;
      if (wr_run) run_lvl_r <= wd_run[7:0];
      if (wr_time) run_time_r <= wd_time[7:0];
      if (wr_ctrl) ctrl_r <= i_wr_data[1:0];
    end
  end

  // Mode gating
  wire vf_mode = ctrl_r[SRPC_CTL_VF];
  wire acc_en = vf_mode && !sel_r[SRPC_SEL_ACC_OFF] && i_ramp_phase == SRPC_PH_ACC;
  wire dec_en = vf_mode && !sel_r[SRPC_SEL_DEC_OFF] && i_ramp_phase == SRPC_PH_DEC;
  wire run_en = vf_mode && !sel_r[SRPC_SEL_RUN_OFF];

  // Motor 2 settings apply only when switching is configured
  wire m2 = ctrl_r[SRPC_CTL_MSW] && i_motor2_sel;
  wire [7:0] lvl_sel = acc_lvl_r[m2];
  wire [7:0] lim_sel = acc_lim_r[m2];

  // Constant-power level: level x base / output, refreshed once per 25-cycle divider pass while output is above base frequency
  wire div_busy;
  wire div_done;
  wire [23:0] div_quo;
  wire [23:0] cp_num = 24'(lvl_sel * i_base_freq);
  wire constant_power_region = i_out_freq > i_base_freq;
  srpc_cp_div #(
    .NW(24),
    .DW(16)
  ) u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_start(!div_busy && constant_power_region),
    .i_num(cp_num),
    .i_den(i_out_freq),
    .o_busy(div_busy),
    .o_done(div_done),
    .o_quo(div_quo)
  );
  wire [7:0] cp_sat = |div_quo[23:8] ? 8'hff : div_quo[7:0];
  wire [7:0] cp_floor = cp_thr_r < lim_sel ? lim_sel : cp_thr_r;
  wire [7:0] eff_nxt = (constant_power_region && cp_floor < lvl_sel) ? cp_floor : lvl_sel;

  // Acceleration rate falls linearly over the last 15 percent
  wire [8:0] acc_thr = {1'b0, eff_thr_r};
  wire acc_reached = i_out_cur_pct >= acc_thr;
  wire [8:0] acc_gap = acc_thr - i_out_cur_pct;
  wire [7:0] acc_slope = 8'(acc_gap[3:0] * 5'h11);
  wire [7:0] rate_nxt = (!acc_en || (!acc_reached && acc_gap >= SRPC_SLOW_BAND)) ? 8'hff :
                        acc_reached ? 8'h00 : acc_slope;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cp_thr_r <= 8'hff;
      eff_thr_r <= SRPC_RST_ACC;
      o_acc_rate <= 8'hff;
      o_acc_halt <= 1'b0;
    end else begin
      if (div_done) cp_thr_r <= cp_sat;
      eff_thr_r <= eff_nxt;
      o_acc_rate <= rate_nxt;
      o_acc_halt <= acc_en && acc_reached;
    end
  end

  // Deceleration pause: equal voltage keeps the present decision
  wire dec_hold_nxt = !dec_en ? 1'b0 : (i_bus_volt > dec_lvl_r) ? 1'b1 :
                      (i_bus_volt < dec_lvl_r) ? 1'b0 : o_dec_hold;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dec_hold <= 1'b0;
    end else begin
      o_dec_hold <= dec_hold_nxt;
    end
  end

  // Run stall: millisecond timing of sustained overcurrent
  wire ms_tick;
  srpc_tick #(
    .PERIOD(TICK_CYC)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_run(run_st_r == SRPC_RUN_TIMING),
    .o_tick(ms_tick)
  );
  wire run_over = i_out_cur_pct > {1'b0, run_lvl_r};
  wire run_under = i_out_cur_pct < ({1'b0, run_lvl_r} - SRPC_RUN_HYST);
  wire [6:0] ms_inc = ms_cnt_r + 7'h01;
  wire run_expired = ms_tick && {1'b0, ms_inc} >= run_time_r;

  always_comb begin
    run_st_nxt = run_st_r;
    if (!run_en) begin
      run_st_nxt = SRPC_RUN_IDLE;
    end else begin
      unique case (run_st_r)
        SRPC_RUN_IDLE: begin
          if (run_over && i_ramp_phase == SRPC_PH_RUN) run_st_nxt = SRPC_RUN_TIMING;
        end
        SRPC_RUN_TIMING: begin
          if (!run_over) run_st_nxt = SRPC_RUN_IDLE;
          else if (run_expired) run_st_nxt = SRPC_RUN_LOWER;
        end
        SRPC_RUN_LOWER: begin
          if (run_under) run_st_nxt = SRPC_RUN_BACK;
        end
        SRPC_RUN_BACK: begin
          if (run_over) run_st_nxt = SRPC_RUN_LOWER;
          else if (i_at_ref) run_st_nxt = SRPC_RUN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_st_r <= SRPC_RUN_IDLE;
      ms_cnt_r <= 7'h00;
      o_run_lower <= 1'b0;
      o_run_back <= 1'b0;
      o_run_dec2 <= 1'b0;
    end else begin
      run_st_r <= run_st_nxt;
      ms_cnt_r <= (run_st_r != SRPC_RUN_TIMING) ? 7'h00 : ms_tick ? ms_inc : ms_cnt_r;
      o_run_lower <= run_st_nxt == SRPC_RUN_LOWER;
      o_run_back <= run_st_nxt == SRPC_RUN_BACK;
      o_run_dec2 <= sel_r[SRPC_SEL_DEC2];
    end
  end

  // Read mux
  wire [7:0] stat = {2'h0, m2, o_run_back, o_run_lower, o_dec_hold, o_acc_halt, o_acc_rate != 8'hff};
  always_comb begin
    unique case (i_addr)
      SRPC_ADR_SEL: rd_nxt = {12'h000, sel_r};
      SRPC_ADR_ACC: rd_nxt = {8'h00, acc_lvl_r[0]};
      SRPC_ADR_DEC: rd_nxt = {5'h00, dec_lvl_r};
      SRPC_ADR_RUN: rd_nxt = {8'h00, run_lvl_r};
      SRPC_ADR_LIM: rd_nxt = {8'h00, acc_lim_r[0]};
      SRPC_ADR_TIME: rd_nxt = {8'h00, run_time_r};
      SRPC_ADR_ACC2: rd_nxt = {8'h00, acc_lvl_r[1]};
      SRPC_ADR_LIM2: rd_nxt = {8'h00, acc_lim_r[1]};
      SRPC_ADR_CTRL: rd_nxt = {14'h0000, ctrl_r};
      SRPC_ADR_STAT: rd_nxt = {8'h00, stat};
      SRPC_ADR_EFF: rd_nxt = {8'h00, eff_thr_r};
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_data <= i_rd_en ? rd_nxt : 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  acc_halt_hit_a: assert property (acc_en && acc_reached |=> o_acc_halt && o_acc_rate == 8'h00)
    else $error("acceleration not halted at level");
  acc_rate_full_a: assert property (acc_en && {1'b0, i_out_cur_pct} + {1'b0, SRPC_SLOW_BAND} <= {1'b0, acc_thr}
    |=> o_acc_rate == 8'hff)
    else $error("acceleration slowed below band");
  acc_slow_band_a: assert property (acc_en && !acc_reached && acc_gap < SRPC_SLOW_BAND
    |=> o_acc_rate < 8'hff && o_acc_rate != 8'h00)
    else $error("acceleration not slowed inside band");
  acc_disabled_a: assert property (sel_r[SRPC_SEL_ACC_OFF] |=> !o_acc_halt && o_acc_rate == 8'hff)
    else $error("acceleration stall acted while disabled");
  dec_pause_a: assert property (dec_en && i_bus_volt > dec_lvl_r |=> o_dec_hold)
    else $error("ramp not paused on high bus voltage");
  dec_resume_a: assert property (o_dec_hold && (i_bus_volt < dec_lvl_r || !dec_en) |=> !o_dec_hold)
    else $error("ramp pause held too long");
  vf_gate_a: assert property (!vf_mode |=> !o_acc_halt && !o_dec_hold && !o_run_lower && !o_run_back)
    else $error("stall prevention active outside V/f mode");
  run_disabled_a: assert property (sel_r[SRPC_SEL_RUN_OFF] |=> run_st_r == SRPC_RUN_IDLE ##1 !o_run_lower)
    else $error("run stall acted while disabled");
  run_lower_time_a: assert property (run_st_r == SRPC_RUN_LOWER && $past(run_st_r) == SRPC_RUN_TIMING
    |-> {1'b0, $past(ms_cnt_r)} + 8'h01 >= $past(run_time_r))
    else $error("frequency lowered before detection time");
  run_back_a: assert property (run_en && run_st_r == SRPC_RUN_LOWER && run_under |=> o_run_back)
    else $error("no ramp back after current fell");
  run_dec_sel_a: assert property (##1 o_run_dec2 == $past(sel_r[SRPC_SEL_DEC2]))
    else $error("wrong deceleration time selected");
  cp_floor_a: assert property (!constant_power_region |=> eff_thr_r == $past(lvl_sel))
    else $error("level reduced below base frequency");
  cp_limit_a: assert property (##1 eff_thr_r >= ($past(lim_sel) < $past(lvl_sel) ? $past(lim_sel) : $past(lvl_sel)))
    else $error("level reduced under floor");
  rd_idle_a: assert property (!i_rd_en |=> o_rd_data == 16'h0000)
    else $error("read data outside read slot");
  acc_phase_a: assert property (i_ramp_phase != SRPC_PH_ACC |=> !o_acc_halt && o_acc_rate == 8'hff)
    else $error("acceleration stall acted outside acceleration");
  dec_phase_a: assert property (i_ramp_phase != SRPC_PH_DEC |=> !o_dec_hold)
    else $error("ramp pause outside deceleration");
  run_entry_a: assert property (run_st_r == SRPC_RUN_IDLE && i_ramp_phase != SRPC_PH_RUN
    |=> run_st_r == SRPC_RUN_IDLE)
    else $error("run stall timing started outside run");
  dec_window_a: assert property (dec_lvl_r >= SRPC_DEC_MIN[VOLT_CLASS]
    && dec_lvl_r <= SRPC_DEC_MAX[VOLT_CLASS])
    else $error("bus level outside class window");
  lvl_range_a: assert property ({3'h0, lvl_sel} >= SRPC_ACC_MIN && {3'h0, lvl_sel} <= SRPC_PCT_MAX)
    else $error("acceleration level out of range");
  lim_range_a: assert property ({3'h0, lim_sel} >= SRPC_LIM_MIN && {3'h0, lim_sel} <= SRPC_LIM_MAX)
    else $error("floor setting out of range");
  run_range_a: assert property ({3'h0, run_lvl_r} >= SRPC_RUN_MIN && {3'h0, run_lvl_r} <= SRPC_PCT_MAX)
    else $error("run level out of range");
  time_range_a: assert property ({3'h0, run_time_r} >= SRPC_TIME_MIN && {3'h0, run_time_r} <= SRPC_TIME_MAX)
    else $error("detection time out of range");

  cov_acc_halt_c: cover property (acc_en ##1 o_acc_halt);
  cov_dec_hold_c: cover property ($rose(o_dec_hold) ##[1:50] $fell(o_dec_hold));
  cov_run_cycle_c: cover property ($rose(o_run_lower) ##[1:200] $rose(o_run_back));
  cov_cp_region_c: cover property (constant_power_region && eff_thr_r < lvl_sel);
  cov_motor2_c: cover property (m2 && eff_thr_r == acc_lvl_r[1]);
endmodule
`default_nettype wire

// file: test/srpc_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module srpc_drive_model
  import srpc_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Scenario settings
  input wire logic [8:0] i_cur_set,
  input wire logic [10:0] i_volt_set,
  input wire srpc_phase_t i_phase_set,
  input wire logic [15:0] i_ref_freq,
  // Stall requests
  input wire logic i_dec_hold,
  input wire logic i_run_lower,
  input wire logic i_run_back,
  // Measurements and ramp state
  output logic [8:0] o_out_cur_pct,
  output logic [10:0] o_bus_volt,
  output logic [15:0] o_out_freq,
  output var srpc_phase_t o_ramp_phase,
  output logic o_at_ref
);
  logic [15:0] freq_r;
  assign o_out_cur_pct = i_cur_set;
  assign o_bus_volt = i_volt_set;
  assign o_out_freq = freq_r;
  assign o_ramp_phase = i_phase_set;
  assign o_at_ref = (freq_r == i_ref_freq);
  // Ramp follows the reference outside run, except while held in deceleration
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      freq_r <= 16'h0000;
    end else if (i_phase_set == SRPC_PH_DEC && i_dec_hold) begin
      freq_r <= freq_r;
    end else if (i_phase_set != SRPC_PH_RUN) begin
      freq_r <= i_ref_freq;
    end else if (i_run_lower) begin
      freq_r <= freq_r - 16'h0001;
    end else if (i_run_back && freq_r < i_ref_freq) begin
      freq_r <= freq_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: test/srpc_stall_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srpc_stall_ctl_tb
  import srpc_pkg::*;
;
  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] addr;
    logic [15:0] data;
    logic [15:0] exp;
  } srpc_row_t;

  logic clk, rst_n, wr_en, rd_en, motor2, at_ref;
  logic [3:0] addr;
  logic [15:0] wdata, rd_data, ref_freq, base_freq, freq, rd_val;
  logic [8:0] cur_set, cur;
  logic [10:0] volt_set, volt;
  srpc_phase_t phase_set, phase;
  logic [7:0] acc_rate;
  logic acc_halt, dec_hold, run_lower, run_dec2, run_back;
  int errors, n_checks, k;
  srpc_row_t rows [$];

  srpc_drive_model u_model (.i_sys_clk(clk), .i_rst_n(rst_n), .i_cur_set(cur_set), .i_volt_set(volt_set),
    .i_phase_set(phase_set), .i_ref_freq(ref_freq), .i_dec_hold(dec_hold), .i_run_lower(run_lower),
    .i_run_back(run_back), .o_out_cur_pct(cur), .o_bus_volt(volt), .o_out_freq(freq),
    .o_ramp_phase(phase), .o_at_ref(at_ref));

  srpc_stall_ctl #(.VOLT_CLASS(1), .TICK_CYC(10)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_out_cur_pct(cur),
    .i_bus_volt(volt), .i_out_freq(freq), .i_base_freq(base_freq), .i_ramp_phase(phase), .i_at_ref(at_ref),
    .i_motor2_sel(motor2), .o_acc_rate(acc_rate), .o_acc_halt(acc_halt), .o_dec_hold(dec_hold),
    .o_run_lower(run_lower), .o_run_dec2(run_dec2), .o_run_back(run_back));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    rd_val = rd_data;
  endtask

  task automatic meas(input srpc_phase_t p, input logic [8:0] c, input logic [10:0] v, input logic [15:0] f);
    @(posedge clk);
    phase_set <= p;
    cur_set <= c;
    volt_set <= v;
    ref_freq <= f;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #800000;
    errors++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    {wr_en, rd_en, motor2} = 3'b000;
    addr = 4'h0;
    wdata = 16'h0000;
    cur_set = 9'd0;
    volt_set = 11'd0;
    phase_set = SRPC_PH_STOP;
    ref_freq = 16'd500;
    base_freq = 16'd1000;
    rows = '{'{0, SRPC_ADR_SEL, 0, 16'(SRPC_RST_SEL)}, '{0, SRPC_ADR_ACC, 0, 16'(SRPC_RST_ACC)},
      '{0, SRPC_ADR_DEC, 0, 16'(SRPC_DEC_DEF[1])}, '{0, SRPC_ADR_RUN, 0, 16'(SRPC_RST_RUN)},
      '{0, SRPC_ADR_LIM, 0, 16'(SRPC_RST_LIM)}, '{0, SRPC_ADR_TIME, 0, 16'(SRPC_RST_TIME)},
      '{0, SRPC_ADR_ACC2, 0, 16'(SRPC_RST_ACC)}, '{0, SRPC_ADR_LIM2, 0, 16'(SRPC_RST_LIM)},
      '{0, SRPC_ADR_CTRL, 0, 16'(SRPC_RST_CTRL)}, '{0, 4'hb, 0, 0}, '{0, SRPC_ADR_EFF, 0, 16'(SRPC_RST_ACC)},
      '{1, SRPC_ADR_ACC, 16'h000a, 16'(SRPC_ACC_MIN)}, '{1, SRPC_ADR_ACC, 16'h012c, 16'(SRPC_PCT_MAX)},
      '{1, SRPC_ADR_ACC, 16'h0096, 16'h0096}, '{1, SRPC_ADR_RUN, 16'h0005, 16'(SRPC_RUN_MIN)},
      '{1, SRPC_ADR_RUN, 16'h012c, 16'(SRPC_PCT_MAX)}, '{1, SRPC_ADR_RUN, 16'h0096, 16'h0096},
      '{1, SRPC_ADR_LIM, 16'h0000, 16'(SRPC_LIM_MIN)}, '{1, SRPC_ADR_LIM, 16'h0096, 16'(SRPC_LIM_MAX)},
      '{1, SRPC_ADR_LIM, 16'h0032, 16'h0032}, '{1, SRPC_ADR_TIME, 16'h0001, 16'(SRPC_TIME_MIN)},
      '{1, SRPC_ADR_TIME, 16'hffff, 16'(SRPC_TIME_MAX)}, '{1, SRPC_ADR_TIME, 16'h0003, 16'h0003},
      '{1, SRPC_ADR_DEC, 16'h0064, 16'(SRPC_DEC_MIN[1])}, '{1, SRPC_ADR_DEC, 16'h07d0, 16'(SRPC_DEC_MAX[1])},
      '{1, SRPC_ADR_DEC, 16'h0302, 16'h0302}, '{1, SRPC_ADR_STAT, 16'hffff, 0}, '{1, 4'hc, 16'h1234, 0},
      '{2, 0, 130, 16'h00ff}, '{2, 0, 135, 16'h00ff}, '{2, 0, 136, 16'h00ee}, '{2, 0, 149, 16'h0011},
      '{2, 0, 150, 16'h0000}, '{2, 0, 180, 16'h0000}};
    settle(4);
    chk("rst_rate", 16'(acc_rate), 16'h00ff);
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].kind == 2'd2) begin
        meas(SRPC_PH_ACC, rows[i].data[8:0], 11'd0, 16'd500);
        settle(3);
        chk("acc_rate", 16'(acc_rate), rows[i].exp);
        chk("acc_halt", 16'(acc_halt), 16'(rows[i].exp == 16'h0));
      end else begin
        if (rows[i].kind == 2'd1) begin
          wr(rows[i].addr, rows[i].data);
        end
        rd(rows[i].addr);
        chk($sformatf("reg%h", rows[i].addr), rd_val, rows[i].exp);
      end
    end
    // Acceleration disabled, then open-loop mode off
    wr(SRPC_ADR_SEL, 16'h0001);
    settle(3);
    chk("acc_off", 16'({acc_halt, acc_rate}), 16'h00ff);
    wr(SRPC_ADR_SEL, 16'h0000);
    wr(SRPC_ADR_CTRL, 16'h0000);
    settle(3);
    chk("vf_off", 16'({acc_halt, acc_rate}), 16'h00ff);
    wr(SRPC_ADR_CTRL, 16'h0001);
    // Constant-power scaling and floor
    meas(SRPC_PH_ACC, 9'd40, 11'd0, 16'd2000);
    settle(40);
    rd(SRPC_ADR_EFF);
    chk("eff_cp", rd_val, 16'(150 * 1000 / 2000));
    meas(SRPC_PH_ACC, 9'd40, 11'd0, 16'd4000);
    settle(40);
    rd(SRPC_ADR_EFF);
    chk("eff_floor", rd_val, 16'(SRPC_RST_LIM));
    meas(SRPC_PH_ACC, 9'd50, 11'd0, 16'd4000);
    settle(3);
    chk("cp_halt", 16'(acc_halt), 16'h0001);
    meas(SRPC_PH_ACC, 9'd40, 11'd0, 16'd1000);
    settle(40);
    rd(SRPC_ADR_EFF);
    chk("eff_base", rd_val, 16'h0096);
    // Motor 2 settings
    wr(SRPC_ADR_ACC2, 16'd100);
    motor2 <= 1'b1;
    settle(40);
    rd(SRPC_ADR_EFF);
    chk("m2_nosw", rd_val, 16'h0096);
    wr(SRPC_ADR_CTRL, 16'h0003);
    settle(40);
    rd(SRPC_ADR_EFF);
    chk("m2_eff", rd_val, 16'd100);
    wr(SRPC_ADR_CTRL, 16'h0001);
    motor2 <= 1'b0;
    // Deceleration hold around the bus level
    meas(SRPC_PH_DEC, 9'd40, 11'd771, 16'd1000);
    settle(2);
    chk("hold_gt", 16'(dec_hold), 16'h0001);
    meas(SRPC_PH_DEC, 9'd40, 11'd770, 16'd1000);
    settle(2);
    chk("hold_eq", 16'(dec_hold), 16'h0001);
    meas(SRPC_PH_DEC, 9'd40, 11'd769, 16'd1000);
    settle(2);
    chk("hold_lt", 16'(dec_hold), 16'h0000);
    wr(SRPC_ADR_SEL, 16'h0002);
    meas(SRPC_PH_DEC, 9'd40, 11'd800, 16'd1000);
    settle(2);
    chk("dec_off", 16'(dec_hold), 16'h0000);
    // Run lowering with decel time 2, hysteresis, ramp back
    wr(SRPC_ADR_SEL, 16'h0008);
    meas(SRPC_PH_RUN, 9'd160, 11'd0, 16'd1000);
    settle(15);
    chk("run_early", 16'(run_lower), 16'h0000);
    k = 15;
    while (run_lower !== 1'b1 && k < 80) begin
      settle(1);
      k++;
    end
    chk("run_time", 16'(k >= 28 && k <= 40), 16'h0001);
    chk("run_dec2", 16'(run_dec2), 16'h0001);
    meas(SRPC_PH_RUN, 9'd149, 11'd0, 16'd1000);
    settle(5);
    chk("run_hyst", 16'(run_lower), 16'h0001);
    meas(SRPC_PH_RUN, 9'd147, 11'd0, 16'd1000);
    settle(2);
    chk("run_back", 16'({run_lower, run_back}), 16'h0001);
    k = 0;
    while (run_back !== 1'b0 && k < 100) begin
      settle(1);
      k++;
    end
    chk("run_ref", 16'({at_ref, run_back}), 16'h0002);
    wr(SRPC_ADR_SEL, 16'h0000);
    settle(2);
    chk("run_dec1", 16'(run_dec2), 16'h0000);
    wr(SRPC_ADR_SEL, 16'h0004);
    meas(SRPC_PH_RUN, 9'd160, 11'd0, 16'd1000);
    settle(60);
    chk("run_off", 16'(run_lower), 16'h0000);
    // Reset in mid-deceleration while holding
    wr(SRPC_ADR_SEL, 16'h0000);
    meas(SRPC_PH_DEC, 9'd40, 11'd800, 16'd1000);
    settle(2);
    chk("pre_rst", 16'(dec_hold), 16'h0001);
    rd(SRPC_ADR_STAT);
    chk("stat_hold", rd_val, 16'h0004);
    @(posedge clk);
    rst_n <= 1'b0;
    settle(1);
    chk("rst_out", 16'({dec_hold, acc_rate}), 16'h00ff);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(SRPC_ADR_TIME);
    chk("rst_time", rd_val, 16'(SRPC_RST_TIME));
    rd(SRPC_ADR_DEC);
    chk("rst_dec", rd_val, 16'(SRPC_DEC_DEF[1]));
    give_verdict();
  end
endmodule
`default_nettype wire
